//--- rtl/prf_pkg.sv
package prf_pkg;

  // ****************************************
  // Register locations and reset values
  // ****************************************
  localparam logic [7:0] SLICE_A_ADDR = 8'h00_D6;
  localparam logic [7:0] SLICE_B_ADDR = 8'h00_D7;
  localparam logic [7:0] PAGE_SELECT_ADDR = 8'h00_DF;
  localparam logic [7:0] SLICE_A_RESET = 8'h00_C0;
  localparam logic [7:0] SLICE_B_RESET = 8'h00_C8;
  localparam logic [7:0] PAGE_SELECT_RESET = 8'h00_00;
  localparam logic BANK_RESET = 1'b0;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [7:0] SET1_BASE = 8'h00_C0;
  localparam logic [7:0] SYSREG_BASE = 8'h00_D0;
  localparam logic [7:0] BANKED_BASE = 8'h00_E0;
  localparam logic [3:0] WORK_PREFIX = 4'h0_C;
  localparam logic [7:0] SLICE_B_STEP = 8'h00_08;
  // Implemented page count of the largest variant
  localparam logic [3:0] IMPL_PAGES = 4'h0_A;
  localparam logic [3:0] DISPLAY_PAGE = 4'h0_F;
  localparam logic [7:0] READ_ZERO = 8'h00_00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_REG = 3'b000,
    MODE_WORK4 = 3'b001,
    MODE_IND_REG = 3'b010,
    MODE_INDEXED = 3'b011,
    MODE_DIRECT = 3'b100,
    MODE_IND_ADDR = 3'b101,
    MODE_IMMED = 3'b110
  } prf_mode_t;

  typedef enum logic [2:0] {
    REGION_PRIME = 3'b000,
    REGION_COMMON = 3'b001,
    REGION_SYSREG = 3'b010,
    REGION_BANKED = 3'b011,
    REGION_SET2 = 3'b100,
    REGION_UNIMPL = 3'b101
  } prf_region_t;

  typedef enum logic [1:0] {
    SRP_BOTH = 2'b00,
    SRP_A = 2'b01,
    SRP_B = 2'b10,
    SRP_NONE = 2'b11
  } prf_srp_t;

  typedef struct packed {
    logic valid;
    prf_mode_t mode;
    logic is_dest;
    logic [7:0] addr;
  } prf_req_t;

  typedef struct packed {
    logic valid;
    prf_region_t region;
    logic [3:0] page;
    logic bank;
    logic [7:0] phys_addr;
    logic fault;
  } prf_resp_t;

  typedef struct packed {
    logic en;
    logic set1;
    logic [7:0] addr;
    logic [7:0] data;
  } prf_wr_t;

endpackage

//--- rtl/prf_addr_map.sv
module prf_addr_map (
  input wire logic mclk,
  input wire logic resetn,
  input wire prf_pkg::prf_req_t req,
  input wire prf_pkg::prf_wr_t reg_wr,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_addr,
  input wire logic srp_valid,
  input wire prf_pkg::prf_srp_t srp_sel,
  input wire logic [7:0] srp_data,
  input wire logic bank_zero_instr,
  input wire logic bank_one_instr,
  output prf_pkg::prf_resp_t resp,
  output logic rd_hit,
  output logic [7:0] rd_data,
  output logic [7:0] slice_a_out,
  output logic [7:0] slice_b_out,
  output logic [7:0] page_select_out,
  output logic bank_out
);
  import prf_pkg::*;

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] slice_a_reg;
  logic [7:0] slice_b_reg;
  logic [7:0] page_select_reg;
  logic bank_reg;
  prf_resp_t resp_next;

  // Decoding of a set-one control register write, shared by all three
  function automatic logic ctrl_hit(input prf_wr_t w, input logic [7:0] loc);
    ctrl_hit = w.en && w.set1 && (w.addr == loc);
  endfunction

  // Page number for a paged access from the direction of the operand
  function automatic logic [3:0] pick_page(input logic [7:0] ps, input logic dest);
    pick_page = dest ? ps[7:4] : ps[3:0];
  endfunction

  // Set-one sub-region of a resolved upper address
  function automatic prf_region_t set1_region(input logic [7:0] a);
    if (a >= BANKED_BASE) begin
      set1_region = REGION_BANKED;
    end else if (a >= SYSREG_BASE) begin
      set1_region = REGION_SYSREG;
    end else begin
      set1_region = REGION_COMMON;
    end
  endfunction

  // ****************************************
  // Slice pointers
  // ****************************************
  // A set-pointer instruction beats a load in the same cycle; the core
  // never issues both, so the choice only fixes a defined outcome.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slice_a_reg <= SLICE_A_RESET;
    end else if (srp_valid && (srp_sel == SRP_BOTH || srp_sel == SRP_A)) begin
      slice_a_reg <= srp_data;
    end else if (ctrl_hit(reg_wr, SLICE_A_ADDR)) begin
      slice_a_reg <= reg_wr.data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slice_b_reg <= SLICE_B_RESET;
    end else if (srp_valid && srp_sel == SRP_BOTH) begin
      slice_b_reg <= 8'(srp_data + SLICE_B_STEP);
    end else if (srp_valid && srp_sel == SRP_B) begin
      slice_b_reg <= srp_data;
    end else if (ctrl_hit(reg_wr, SLICE_B_ADDR)) begin
      slice_b_reg <= reg_wr.data;
    end
  end

  // ****************************************
  // Page select and bank
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      page_select_reg <= PAGE_SELECT_RESET;
    end else if (ctrl_hit(reg_wr, PAGE_SELECT_ADDR)) begin
      page_select_reg <= reg_wr.data;
    end
  end

  // Bank one wins when both strobes arrive together
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bank_reg <= BANK_RESET;
    end else if (bank_one_instr) begin
      bank_reg <= 1'b1;
    end else if (bank_zero_instr) begin
      bank_reg <= 1'b0;
    end
  end

  // ****************************************
  // Operand resolution
  // ****************************************
  // Resolution reads the registered pointers, so a write in the same
  // cycle only steers the following request.
  always_comb begin
    logic [7:0] ptr;
    logic [3:0] pg;
    logic work;
    ptr = slice_a_reg;
    pg = pick_page(page_select_reg, req.is_dest);
    work = 1'b0;
    resp_next.valid = req.valid;
    resp_next.region = REGION_PRIME;
    resp_next.page = pg;
    resp_next.bank = 1'b0;
    resp_next.phys_addr = req.addr;
    resp_next.fault = 1'b0;
    if (req.mode == MODE_WORK4) begin
      work = 1'b1;
    end else if (req.mode == MODE_REG && req.addr[7:4] == WORK_PREFIX) begin
      work = 1'b1;
    end
    if (work) begin
      ptr = req.addr[3] ? slice_b_reg : slice_a_reg;
      resp_next.phys_addr = {ptr[7:3], req.addr[2:0]};
    end
    if (resp_next.phys_addr >= SET1_BASE) begin
      if (!work && (req.mode == MODE_IND_REG || req.mode == MODE_INDEXED)) begin
        resp_next.region = REGION_SET2;
        resp_next.fault = (pg >= IMPL_PAGES);
        if (pg >= IMPL_PAGES) begin
          resp_next.region = REGION_UNIMPL;
        end
      end else begin
        // Working references land in set one, never in set two
        resp_next.region = set1_region(resp_next.phys_addr);
        resp_next.page = 4'h0_0;
        if (resp_next.region == REGION_BANKED) begin
          resp_next.bank = bank_reg;
        end
      end
    end else begin
      resp_next.region = REGION_PRIME;
      if (pg >= IMPL_PAGES && pg != DISPLAY_PAGE) begin
        resp_next.region = REGION_UNIMPL;
        resp_next.fault = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      resp <= '0;
    end else begin
      resp <= resp_next;
    end
  end

  // ****************************************
  // Register read-back
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_hit <= 1'b0;
      rd_data <= READ_ZERO;
    end else begin
      rd_hit <= 1'b0;
      rd_data <= READ_ZERO;
      if (reg_rd_en && reg_rd_addr == SLICE_A_ADDR) begin
        rd_hit <= 1'b1;
        rd_data <= slice_a_reg;
      end else if (reg_rd_en && reg_rd_addr == SLICE_B_ADDR) begin
        rd_hit <= 1'b1;
        rd_data <= slice_b_reg;
      end else if (reg_rd_en && reg_rd_addr == PAGE_SELECT_ADDR) begin
        rd_hit <= 1'b1;
        rd_data <= page_select_reg;
      end
    end
  end

  // Mirrors of the live control state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slice_a_out <= SLICE_A_RESET;
      slice_b_out <= SLICE_B_RESET;
      page_select_out <= PAGE_SELECT_RESET;
      bank_out <= BANK_RESET;
    end else begin
      slice_a_out <= slice_a_reg;
      slice_b_out <= slice_b_reg;
      page_select_out <= page_select_reg;
      bank_out <= bank_reg;
    end
  end

endmodule

//--- test/prf_addr_map_asserts.sv
// ****
// Port checks
// ****
module prf_addr_map_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire prf_pkg::prf_req_t req,
  input wire prf_pkg::prf_wr_t reg_wr,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_addr,
  input wire logic srp_valid,
  input wire prf_pkg::prf_srp_t srp_sel,
  input wire logic [7:0] srp_data,
  input wire prf_pkg::prf_resp_t resp,
  input wire logic rd_hit,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] slice_a_out,
  input wire logic [7:0] slice_b_out,
  input wire logic [7:0] page_select_out,
  input wire logic bank_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import prf_pkg::*;
  // Mirrors lag one cycle, so at answer time they equal the value used
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_resp_lag: assert property (1 |=> resp.valid == $past(req.valid))
    else $error("resp valid lag");
  a_work_join: assert property (req.valid && req.mode == MODE_WORK4 |=>
    resp.region != REGION_SET2 && resp.phys_addr[2:0] == $past(req.addr[2:0])
    && resp.phys_addr[7:3] == ($past(req.addr[3]) ? slice_b_out[7:3] : slice_a_out[7:3]))
    else $error("working address");
  a_set2_route: assert property (req.valid && req.addr >= SET1_BASE
    && req.mode inside {MODE_IND_REG, MODE_INDEXED} |=> resp.region ==
    ((($past(req.is_dest) ? page_select_out[7:4] : page_select_out[3:0]) < IMPL_PAGES)
    ? REGION_SET2 : REGION_UNIMPL)) else $error("set two route");
  a_page_pick: assert property (req.valid && req.mode != MODE_WORK4 && req.addr < SET1_BASE
    |=> resp.page == ($past(req.is_dest) ? page_select_out[7:4] : page_select_out[3:0]))
    else $error("page nibble");
  a_bank_direct: assert property (req.valid && req.mode == MODE_REG
    && req.addr >= BANKED_BASE |=> resp.region == REGION_BANKED && resp.bank == bank_out)
    else $error("banked access");
  a_srp_pair: assert property (srp_valid && srp_sel == SRP_BOTH ##1 !srp_valid && !reg_wr.en
    |=> slice_a_out == $past(srp_data, 2) && slice_b_out == $past(srp_data, 2) + SLICE_B_STEP)
    else $error("pointer pair");
  // Mirror shows the effect of this edge two samples later
  a_srp_keep: assert property (srp_valid && srp_sel == SRP_B && !reg_wr.en
    |=> ##1 $stable(slice_a_out)) else $error("pointer a moved");
  a_rd_page: assert property (reg_rd_en && reg_rd_addr == PAGE_SELECT_ADDR
    |=> rd_hit && rd_data == page_select_out) else $error("page read");
endmodule
bind prf_addr_map prf_addr_map_asserts chk_u (.*);

//--- test/prf_cpu_model.sv
// ****
// Operand side of the core
// ****
module prf_cpu_model (
  input wire logic mclk,
  output prf_pkg::prf_req_t req,
  output prf_pkg::prf_wr_t reg_wr,
  output logic reg_rd_en,
  output logic [7:0] reg_rd_addr,
  output logic srp_valid,
  output prf_pkg::prf_srp_t srp_sel,
  output logic [7:0] srp_data,
  output logic bank_zero_instr,
  output logic bank_one_instr
);
  timeunit 1ns;
  timeprecision 1ns;
  import prf_pkg::*;
  initial begin
    {req, reg_wr, reg_rd_en, reg_rd_addr, srp_valid, srp_data} = '0;
    {bank_zero_instr, bank_one_instr} = 2'b00;
    srp_sel = SRP_NONE;
  end
  // Every op is a one-cycle pulse, dropped at the next falling edge
  task automatic idle();
    @(negedge mclk);
    {req.valid, reg_wr.en, reg_rd_en, srp_valid, bank_zero_instr, bank_one_instr} = '0;
  endtask
  // Page select is loaded before any other page is touched
  task automatic resolve(input prf_mode_t m, input logic d, input logic [7:0] a);
    @(negedge mclk);
    req = '{1'b1, m, d, a};
    idle();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = '{1'b1, 1'b1, a, d};
    idle();
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_rd_en = 1'b1;
    reg_rd_addr = a;
    idle();
  endtask
  // Callers may leave pointer a above pointer b
  task automatic set_pointer_instr(input prf_srp_t s, input logic [7:0] d);
    @(negedge mclk);
    {srp_valid, srp_sel, srp_data} = {1'b1, s, d};
    idle();
  endtask
  task automatic bank(input logic one);
    @(negedge mclk);
    {bank_one_instr, bank_zero_instr} = {one, !one};
    idle();
  endtask
endmodule

//--- test/prf_addr_map_bench.sv
module prf_addr_map_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import prf_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  prf_req_t req;
  prf_wr_t reg_wr;
  prf_srp_t srp_sel;
  prf_resp_t resp;
  logic reg_rd_en, srp_valid, bank_zero_instr, bank_one_instr, rd_hit, bank_out;
  logic [7:0] reg_rd_addr, srp_data, rd_data, slice_a_out, slice_b_out, page_select_out;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  always #20 mclk = ~mclk;
  prf_cpu_model cpu_u (.*);
  prf_addr_map dut_u (.*);
  // ****
  // Shared checks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address of an unimplemented place is left unchecked
  task automatic res(input prf_mode_t m, input logic d, input logic [7:0] a,
                     input prf_region_t r, input logic [3:0] p, input logic [7:0] x);
    cpu_u.resolve(m, d, a);
    check({resp.valid, resp.region, resp.page, resp.fault}, {1'b1, r, p, r == REGION_UNIMPL});
    if (r != REGION_UNIMPL) check(resp.phys_addr, x);
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    check({slice_a_out, slice_b_out, page_select_out, 7'h00, bank_out}, 32'hC0C8_0000);
    res(MODE_WORK4, 1'b0, 8'h06, REGION_COMMON, 4'h0, 8'hC6);
    res(MODE_REG, 1'b1, 8'h25, REGION_PRIME, 4'h0, 8'h25);
  endtask
  task automatic t_page();
    cpu_u.wr(PAGE_SELECT_ADDR, 8'h3A);
    res(MODE_IND_REG, 1'b0, 8'hC5, REGION_UNIMPL, 4'hA, 8'hC5);
    res(MODE_INDEXED, 1'b1, 8'hC5, REGION_SET2, 4'h3, 8'hC5);
    res(MODE_REG, 1'b1, 8'hD5, REGION_SYSREG, 4'h0, 8'hD5);
    cpu_u.rd(PAGE_SELECT_ADDR);
    check({rd_hit, rd_data}, 9'h13A);
    cpu_u.rd(8'h10);
    check({rd_hit, rd_data}, 9'h000);
    cpu_u.wr(PAGE_SELECT_ADDR, 8'hF9);
    res(MODE_DIRECT, 1'b1, 8'h40, REGION_PRIME, 4'hF, 8'h40);
    res(MODE_IND_ADDR, 1'b0, 8'h40, REGION_PRIME, 4'h9, 8'h40);
  endtask
  task automatic t_slice();
    cpu_u.set_pointer_instr(SRP_BOTH, 8'h70);
    cpu_u.set_pointer_instr(SRP_B, 8'h48);
    res(MODE_WORK4, 1'b0, 8'h05, REGION_PRIME, 4'h9, 8'h75);
    res(MODE_REG, 1'b1, 8'hCB, REGION_PRIME, 4'hF, 8'h4B);
    check({slice_a_out, slice_b_out}, 16'h7048);
    cpu_u.wr(SLICE_A_ADDR, 8'hA0);
    cpu_u.rd(SLICE_A_ADDR);
    check({rd_hit, rd_data}, 9'h1A0);
    cpu_u.set_pointer_instr(SRP_A, 8'h30);
    res(MODE_WORK4, 1'b1, 8'h01, REGION_PRIME, 4'hF, 8'h31);
    check({slice_a_out, slice_b_out}, 16'h3048);
  endtask
  task automatic t_bank();
    cpu_u.bank(1'b1);
    res(MODE_REG, 1'b0, 8'hE4, REGION_BANKED, 4'h0, 8'hE4);
    check(resp.bank, 1'b1);
    cpu_u.bank(1'b0);
    res(MODE_REG, 1'b0, 8'hF1, REGION_BANKED, 4'h0, 8'hF1);
    check(resp.bank, 1'b0);
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    t_reset();
    t_page();
    t_slice();
    t_bank();
    give_verdict();
  end
endmodule
